// ### verilog/pmp_cfg.svh
// Notes on behaviour
// - Poll all 32 addresses continuously while enabled
// - Responding bitmap bit set when PHY answers
// - Link bit needs response and link status
// - User reads also update the responding bitmap
// - Idle, no bus activity until enabled
// - Preamble by default, software may suppress
// - Management clock from programmable divider
// - Monitored PHY address from select field
// - Monitored link change sets raw, masked flags
// - User frame fields come from slot inputs
// - Launch runs whole transaction without CPU
// - Completion clears launch, sets slot done flag
// - Masked done flag gated by mask, interrupts
// - Two pending slots served round robin
// - Per-slot acknowledge bit for read answers
// - Read data stored, acknowledge set as launch clears
`ifndef PMP_CFG_SVH
`define PMP_CFG_SVH
`define PMP_NUM_PHY     32
`define PMP_NUM_SLOT    2
`define PMP_DIV_W       16
`define PMP_LAST_BIT    5'h1F
`define PMP_DRIVE_BITS  5'h0E
`define PMP_ACK_BIT     5'h0F
`define PMP_DATA_FIRST  5'h10
`define PMP_START       2'h1
`define PMP_OP_RD       2'h2
`define PMP_OP_WR       2'h1
`define PMP_TA          2'h2
`define PMP_STATUS_REG  5'h01
`define PMP_LINK_BIT    2
`endif

// ### verilog/pmp_pkg.sv
`include "pmp_cfg.svh"
package pmp_pkg;
   // Frame engine states, Gray coded along idle-pre-frame-done
   typedef enum logic [1:0] {
      PMP_IDLE  = 2'h0,
      PMP_PRE   = 2'h1,
      PMP_FRAME = 2'h3,
      PMP_DONE  = 2'h2
   } pmp_state_t;

   // Complete state of the poller
   typedef struct packed {
      pmp_state_t       state;
      logic             mdc;
      logic [4:0]       bitCnt;
      logic [31:0]      shiftOut;
      logic [15:0]      shiftIn;
      logic             ack;
      logic             curUser;
      logic             curSlot;
      logic             curWrite;
      logic [4:0]       curPhy;
      logic [4:0]       pollAddr;
      logic             rrLast;
      logic [1:0]       busy;
      logic [1:0]       slotWrite;
      logic [1:0][4:0]  slotPhy;
      logic [1:0][4:0]  slotReg;
      logic [1:0][15:0] slotData;
      logic [1:0][15:0] rdData;
      logic [1:0]       ackBits;
      logic [1:0]       doneRaw;
      logic [1:0]       doneMask;
      logic             linkRaw;
      logic             linkMasked;
      logic             monLink;
      logic [31:0]      alive;
      logic [31:0]      linkMap;
      logic             mdioOut;
      logic             mdioOe;
   } pmp_state_reg_t;
endpackage

// ### verilog/pmp_sync.sv
`timescale 1ns/1ps
module pmp_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   input  wire logic             clkEn,
   // Asynchronous level in, synchronous level out
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_reg;   // First stage, read only by second

   // Two flip-flop synchroniser
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_reg <= '0;
         syncOut  <= '0;
      end else if (clkEn) begin
         meta_reg <= asyncIn;
         syncOut  <= meta_reg;
      end
   end
endmodule

// ### verilog/pmp_clk_div.sv
`timescale 1ns/1ps
module pmp_clk_div #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   input  wire logic             clkEn,
   // Half period of the management clock, minus one
   input  wire logic [DIV_W-1:0] divide,
   // One-cycle pulse per management clock half period
   output logic                  tick
);
   logic [DIV_W-1:0] count_reg;   // Cycles since last tick

   // Tick every divide+1 cycles, so the pin period is 2*(divide+1)
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_reg <= '0;
         tick      <= 1'b0;
      end else if (clkEn) begin
         if (count_reg >= divide) begin
            count_reg <= '0;
            tick      <= 1'b1;
         end else begin
            count_reg <= count_reg + DIV_W'(1);
            tick      <= 1'b0;
         end
      end
   end
endmodule

// ### verilog/pmp_poller.sv
`timescale 1ns/1ps
`include "pmp_cfg.svh"
module pmp_poller
   import pmp_pkg::*;
(
   // Clock, reset and clock enable
   input  wire logic                  ref_clk,
   input  wire logic                  sys_rst,
   input  wire logic                  clkEn,
   // Control settings
   input  wire logic                  enable,
   input  wire logic                  preambleOff,
   input  wire logic [`PMP_DIV_W-1:0] clock_divide_field,
   // Monitored PHY selection
   input  wire logic [4:0]            monitored_phy_address,
   input  wire logic                  link_change_irq_enable,
   input  wire logic                  linkChangeClear,
   // User access slots, launch pulses
   input  wire logic [1:0]            userLaunch,
   input  wire logic [1:0]            userWriteDir,
   input  wire logic [1:0][4:0]       userPhyAddr,
   input  wire logic [1:0][4:0]       userRegAddr,
   input  wire logic [1:0][15:0]      userWriteData,
   output logic      [1:0]            userBusy,
   output logic      [1:0]            userAck,
   output logic      [1:0][15:0]      userReadData,
   // Command completion flags and mask
   input  wire logic [1:0]            cmdDoneClear,
   input  wire logic [1:0]            cmd_done_mask_set_reg,
   input  wire logic [1:0]            cmd_done_mask_clear_reg,
   output logic      [1:0]            cmd_done_raw_flags,
   output logic      [1:0]            cmd_done_masked_flags,
   output logic      [1:0]            cmdDoneMask,
   output logic                       cmdIrq,
   // Link change flags
   output logic                       link_change_raw_flag,
   output logic                       link_change_masked_flag,
   // Polling results
   output logic      [31:0]           aliveMap,
   output logic      [31:0]           linkMap,
   // Management bus pins
   output logic                       mgmt_clock_pin,
   input  wire logic                  mdioIn,
   output logic                       mdioOut,
   output logic                       mdioOe
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   ////////////////////////////////////////////////////////////////////////

   pmp_state_reg_t r_reg;        // Registered state
   pmp_state_reg_t r_next;       // Next state
   logic           tick;         // Management clock half-period pulse
   logic           mdioSync;     // Data pin after two flip-flops

   // Picks the frame bit for a given position, MSB goes first on the wire
   function automatic logic frameBit(input logic [31:0] frame,
                                     input logic [4:0]  pos);
      frameBit = frame[`PMP_LAST_BIT - pos];
   endfunction

   // Builds a full clause-22 frame for read or write
   function automatic logic [31:0] buildFrame(input logic        wr,
                                              input logic [4:0]  phy,
                                              input logic [4:0]  regIdx,
                                              input logic [15:0] data);
      buildFrame = {`PMP_START, wr ? `PMP_OP_WR : `PMP_OP_RD, phy, regIdx,
                    `PMP_TA, data};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Submodules
   ////////////////////////////////////////////////////////////////////////

   // Management clock timing from the programmed divider
   pmp_clk_div #(
      .DIV_W   (`PMP_DIV_W)
   ) u_div (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .clkEn   (clkEn),
      .divide  (clock_divide_field),
      .tick    (tick)
   );

   // PHY drives the pin off its own timing: synchronise
   pmp_sync #(
      .WIDTH   (1)
   ) u_sync (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .clkEn   (clkEn),
      .asyncIn (mdioIn),
      .syncOut (mdioSync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   ////////////////////////////////////////////////////////////////////////

   // Software-side updates first, then bus events, so hardware sets win
   always_comb begin
      logic       pickSlot;
      logic       newLink;
      logic [1:0] waiting;
      r_next   = r_reg;
      pickSlot = 1'b0;
      newLink  = 1'b0;
      waiting  = r_reg.busy;

      // Mask set and clear; a set in the same cycle as a clear wins
      r_next.doneMask = (r_reg.doneMask & ~cmd_done_mask_clear_reg)
                        | cmd_done_mask_set_reg;

      // Software clears of the sticky flags
      r_next.doneRaw = r_reg.doneRaw & ~cmdDoneClear;
      if (linkChangeClear) begin
         r_next.linkRaw    = 1'b0;
         r_next.linkMasked = 1'b0;
      end

      // Capture launched requests; a launch on a busy slot is ignored
      for (int i = 0; i < `PMP_NUM_SLOT; i++) begin
         if (userLaunch[i] && !r_reg.busy[i]) begin
            r_next.busy[i]      = 1'b1;
            r_next.ackBits[i]   = 1'b0;
            r_next.slotWrite[i] = userWriteDir[i];
            r_next.slotPhy[i]   = userPhyAddr[i];
            r_next.slotReg[i]   = userRegAddr[i];
            r_next.slotData[i]  = userWriteData[i];
         end
      end

      // Bus engine advances only on management clock half periods
      if (tick) begin
         case (r_reg.state)
            PMP_IDLE: begin
               // Nothing moves on the pins until software enables
               if (enable) begin
                  // Users first; two waiting slots alternate
                  if (waiting[0] && waiting[1]) begin
                     pickSlot = ~r_reg.rrLast;
                  end else begin
                     pickSlot = waiting[1];
                  end
                  r_next.bitCnt  = 5'h00;
                  r_next.ack     = 1'b0;
                  r_next.shiftIn = 16'h0000;
                  if (|waiting) begin
                     r_next.curUser  = 1'b1;
                     r_next.curSlot  = pickSlot;
                     r_next.curWrite = r_reg.slotWrite[pickSlot];
                     r_next.curPhy   = r_reg.slotPhy[pickSlot];
                     r_next.shiftOut = buildFrame(r_reg.slotWrite[pickSlot],
                                                  r_reg.slotPhy[pickSlot],
                                                  r_reg.slotReg[pickSlot],
                                                  r_reg.slotData[pickSlot]);
                  end else begin
                     // Background poll of the generic status register
                     r_next.curUser  = 1'b0;
                     r_next.curWrite = 1'b0;
                     r_next.curPhy   = r_reg.pollAddr;
                     r_next.shiftOut = buildFrame(1'b0, r_reg.pollAddr,
                                                  `PMP_STATUS_REG, 16'h0000);
                  end
                  r_next.mdioOe = 1'b1;
                  if (preambleOff) begin
                     r_next.state   = PMP_FRAME;
                     r_next.mdioOut = 1'b0;
                  end else begin
                     r_next.state   = PMP_PRE;
                     r_next.mdioOut = 1'b1;
                  end
               end
            end

            PMP_PRE: begin
               // Preamble: ones for one full bit count
               r_next.mdc = ~r_reg.mdc;
               if (!r_reg.mdc) begin
                  // Rising edge: count the bit just sent
                  if (r_reg.bitCnt == `PMP_LAST_BIT) begin
                     r_next.bitCnt = 5'h00;
                     r_next.state  = PMP_FRAME;
                  end else begin
                     r_next.bitCnt = r_reg.bitCnt + 5'h01;
                  end
               end
            end

            PMP_FRAME: begin
               r_next.mdc = ~r_reg.mdc;
               if (!r_reg.mdc) begin
                  // Rising edge: PHY data is stable, sample it
                  if (r_reg.bitCnt == `PMP_ACK_BIT) begin
                     // A present PHY pulls the second turnaround bit low
                     r_next.ack = ~mdioSync;
                  end
                  if (r_reg.bitCnt >= `PMP_DATA_FIRST) begin
                     r_next.shiftIn = {r_reg.shiftIn[14:0], mdioSync};
                  end
                  if (r_reg.bitCnt == `PMP_LAST_BIT) begin
                     r_next.state = PMP_DONE;
                  end else begin
                     r_next.bitCnt = r_reg.bitCnt + 5'h01;
                  end
               end else begin
                  // Falling edge: present the next bit, release for reads
                  r_next.mdioOut = frameBit(r_reg.shiftOut, r_reg.bitCnt);
                  r_next.mdioOe  = r_reg.curWrite
                                   || (r_reg.bitCnt < `PMP_DRIVE_BITS);
               end
            end

            PMP_DONE: begin
               // Last falling edge: release the pin and post results
               r_next.mdc     = 1'b0;
               r_next.mdioOe  = 1'b0;
               r_next.state   = PMP_IDLE;
               if (r_reg.curUser) begin
                  r_next.busy[r_reg.curSlot]    = 1'b0;
                  r_next.doneRaw[r_reg.curSlot] = 1'b1;
                  r_next.rrLast                 = r_reg.curSlot;
                  if (!r_reg.curWrite) begin
                     // Read data and acknowledge land with the launch clear
                     r_next.rdData[r_reg.curSlot]  = r_reg.shiftIn;
                     r_next.ackBits[r_reg.curSlot] = r_reg.ack;
                     r_next.alive[r_reg.curPhy]    = r_reg.ack;
                  end
               end else begin
                  // Poll result overwrites the old one either way
                  r_next.alive[r_reg.curPhy]   = r_reg.ack;
                  newLink = r_reg.ack && r_reg.shiftIn[`PMP_LINK_BIT];
                  r_next.linkMap[r_reg.curPhy] = newLink;
                  r_next.pollAddr = r_reg.pollAddr + 5'h01;
                  if (r_reg.curPhy == monitored_phy_address) begin
                     r_next.monLink = newLink;
                     if (newLink != r_reg.monLink && link_change_irq_enable) begin
                        r_next.linkRaw    = 1'b1;
                        r_next.linkMasked = 1'b1;
                     end
                  end
               end
            end

            default: begin
               r_next.state  = PMP_IDLE;
               r_next.mdioOe = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   ////////////////////////////////////////////////////////////////////////

   // Whole state frozen while the clock enable is low
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         r_reg <= '0;
      end else if (clkEn) begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   ////////////////////////////////////////////////////////////////////////

   // Status straight from registers
   assign userBusy                = r_reg.busy;
   assign userAck                 = r_reg.ackBits;
   assign userReadData            = r_reg.rdData;
   assign cmd_done_raw_flags      = r_reg.doneRaw;
   assign cmdDoneMask             = r_reg.doneMask;
   assign link_change_raw_flag    = r_reg.linkRaw;
   assign link_change_masked_flag = r_reg.linkMasked;
   assign aliveMap                = r_reg.alive;
   assign linkMap                 = r_reg.linkMap;

   // Masked completion follows the mask, which may change later
   assign cmd_done_masked_flags = r_reg.doneRaw & r_reg.doneMask;
   assign cmdIrq                = |cmd_done_masked_flags;

   // Pins
   assign mgmt_clock_pin = r_reg.mdc;
   assign mdioOut        = r_reg.mdioOut;
   assign mdioOe         = r_reg.mdioOe;
endmodule

// ### test/pmp_poller_props.sv
`timescale 1ns/1ps
`include "pmp_cfg.svh"
module pmp_poller_props (
   // Clock and reset
   input wire logic                  ref_clk,
   input wire logic                  sys_rst,
   // Settings
   input wire logic                  enable,
   input wire logic [`PMP_DIV_W-1:0] clock_divide_field,
   input wire logic                  link_change_irq_enable,
   // User slots and flags
   input wire logic [1:0]            userLaunch,
   input wire logic [1:0]            userBusy,
   input wire logic [1:0]            userAck,
   input wire logic [1:0]            cmd_done_raw_flags,
   input wire logic [1:0]            cmd_done_masked_flags,
   input wire logic [1:0]            cmdDoneMask,
   input wire logic                  cmdIrq,
   input wire logic                  link_change_raw_flag,
   // Maps and pins
   input wire logic [31:0]           aliveMap,
   input wire logic [31:0]           linkMap,
   input wire logic                  mgmt_clock_pin,
   input wire logic                  mdioOe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////
   logic                  everEn_reg;    // Enable seen since reset
   logic                  mdcLast_reg;   // Clock pin one cycle ago
   logic [`PMP_DIV_W-1:0] sinceEdge_reg; // Saturates, so a still pin never wraps
   // Track enable and time between clock pin edges
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         everEn_reg    <= 1'b0;
         mdcLast_reg   <= 1'b0;
         sinceEdge_reg <= '0;
      end else begin
         everEn_reg  <= everEn_reg | enable;
         mdcLast_reg <= mgmt_clock_pin;
         if (mgmt_clock_pin != mdcLast_reg) begin
            sinceEdge_reg <= '0;
         end else if (~&sinceEdge_reg) begin
            sinceEdge_reg <= sinceEdge_reg + 1'b1;
         end
      end
   end
   ////////////////////////////////////////////////////////////
   quiet_before_en_a: assert property (!everEn_reg |-> !mdioOe && !mgmt_clock_pin)
      else $error("bus active before enable");
   half_period_a: assert property ((mgmt_clock_pin != mdcLast_reg) |-> sinceEdge_reg >= clock_divide_field)
      else $error("management clock half period too short");
   launch_zero_a: assert property (userLaunch[0] && !userBusy[0] |=> userBusy[0] && !userAck[0])
      else $error("slot 0 launch not taken");
   launch_one_a: assert property (userLaunch[1] && !userBusy[1] |=> userBusy[1] && !userAck[1])
      else $error("slot 1 launch not taken");
   done_zero_a: assert property ($fell(userBusy[0]) |-> cmd_done_raw_flags[0])
      else $error("slot 0 finished without done flag");
   done_one_a: assert property ($rose(cmd_done_raw_flags[1]) |-> $fell(userBusy[1]))
      else $error("slot 1 done flag without finish");
   masked_flags_a: assert property (cmd_done_masked_flags == (cmd_done_raw_flags & cmdDoneMask)
      && cmdIrq == (|cmd_done_masked_flags))
      else $error("masked done flags or irq wrong");
   link_in_alive_a: assert property ((linkMap & ~aliveMap) == 32'h0)
      else $error("link bit without responding bit");
   link_gate_a: assert property ($rose(link_change_raw_flag) |-> $past(link_change_irq_enable))
      else $error("link flag raised while disabled");
   ack_idle_a: assert property (userAck[0] |-> !userBusy[0])
      else $error("acknowledge while slot busy");
endmodule
bind pmp_poller pmp_poller_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst), .enable(enable),
   .clock_divide_field(clock_divide_field), .link_change_irq_enable(link_change_irq_enable),
   .userLaunch(userLaunch), .userBusy(userBusy), .userAck(userAck), .cmd_done_raw_flags(cmd_done_raw_flags),
   .cmd_done_masked_flags(cmd_done_masked_flags), .cmdDoneMask(cmdDoneMask), .cmdIrq(cmdIrq),
   .link_change_raw_flag(link_change_raw_flag), .aliveMap(aliveMap), .linkMap(linkMap),
   .mgmt_clock_pin(mgmt_clock_pin), .mdioOe(mdioOe));

// ### test/pmp_phy_model.sv
`timescale 1ns/1ps
module pmp_phy_model (
   // Bus side
   input  wire logic mdc,
   input  wire logic mdioLine,
   // Own clock, unrelated to the controller
   input  wire logic linkClk,
   output logic      phyOe,
   output logic      phyOut
);
   logic [31:0] present;      // Addresses that answer
   logic [31:0] linkUp;       // Addresses with a link
   logic [31:0] seenMask;     // Status polls seen
   logic [13:0] hdr;          // Header bits as sampled
   logic [15:0] dat;          // Data bits as sampled
   logic [15:0] rdWord;       // Word to answer with
   logic [15:0] wrData;       // Last written word
   logic        isWr;         // Frame is a write
   logic [4:0]  logPhy [$];   // Non-status frames in order
   logic        answer;       // Drive this read
   logic        nOe;          // Pending drive state
   logic        nOut;         // Pending drive value
   int          onesRun, zRun, lastPre, frames, bitIdx;
   initial begin
      present = 32'h24;
      linkUp = 32'h20;
      seenMask = '0;
      hdr = '1;
      answer = 1'b0;
      nOe = 1'b0;
      nOut = 1'b1;
      {onesRun, zRun, lastPre, frames, bitIdx} = '0;
   end
   // Decode at each rising edge
   always @(posedge mdc) begin
      hdr = {hdr[12:0], mdioLine};
      dat = {dat[14:0], mdioLine};
      if (bitIdx == 0) begin
         if (hdr[1:0] == 2'h1) begin
            lastPre = zRun;
            bitIdx = 2;
            frames++;
            onesRun = 0;
         end else if (mdioLine) begin
            onesRun++;
         end else begin
            zRun = onesRun;
            onesRun = 0;
         end
      end else begin
         bitIdx++;
      end
      if (bitIdx == 14) begin
         answer = hdr[11:10] == 2'h2 && present[hdr[9:5]];
         rdWord = (hdr[4:0] == 5'h01) ? {13'h0, linkUp[hdr[9:5]], 2'h0} : {3'h5, hdr[9:5], hdr[4:0], 3'h2};
         if (hdr[4:0] == 5'h01) seenMask[hdr[9:5]] = 1'b1;
         else logPhy.push_back(hdr[9:5]);
         isWr = hdr[11:10] == 2'h1;
      end
      if (bitIdx == 32) begin
         if (isWr) wrData = dat;
         bitIdx = 0;
         hdr = '1;
      end
   end
   // Next bit after each falling edge
   always @(negedge mdc) begin
      nOe = answer && bitIdx >= 15 && bitIdx <= 31;
      nOut = (bitIdx == 15) ? 1'b0 : rdWord[(31 - bitIdx) % 16];
   end
   // Line moves only on the own clock
   always @(posedge linkClk) begin
      phyOe <= nOe;
      phyOut <= nOe ? nOut : ~phyOut;
   end
endmodule

// ### test/phy_management_poller_tb_top.sv
`timescale 1ns/1ps
`include "pmp_cfg.svh"
module phy_management_poller_tb_top;
   logic             ref_clk, linkClk, sys_rst;        // Clocks and reset
   logic             enable, preambleOff, linkIrqEn, linkClr;
   logic [`PMP_DIV_W-1:0] divide;                      // Half period minus one
   logic [4:0]       monAddr;
   logic [1:0]       launch, wrDir, doneClr, maskSet, maskClr, busy, ack, rawF, mskF, mask;
   logic [1:0][4:0]  phyAddr, regAddr;
   logic [1:0][15:0] wrData, rdData;
   logic             irq, linkRaw, linkMsk, mdc, mdioOut, mdioOe, phyOe, phyOut;
   logic [31:0]      alive, link;
   wire              mdioIn = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1); // Pull-up when released
   int               fails, total_checks, cycles;
   ////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial begin
      linkClk = 1'b0;
      #7;
      forever #40 linkClk = ~linkClk;
   end
   pmp_poller dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(1'b1), .enable(enable), .preambleOff(preambleOff),
      .clock_divide_field(divide), .monitored_phy_address(monAddr), .link_change_irq_enable(linkIrqEn),
      .linkChangeClear(linkClr), .userLaunch(launch), .userWriteDir(wrDir), .userPhyAddr(phyAddr),
      .userRegAddr(regAddr), .userWriteData(wrData), .userBusy(busy), .userAck(ack), .userReadData(rdData),
      .cmdDoneClear(doneClr), .cmd_done_mask_set_reg(maskSet), .cmd_done_mask_clear_reg(maskClr),
      .cmd_done_raw_flags(rawF), .cmd_done_masked_flags(mskF), .cmdDoneMask(mask), .cmdIrq(irq),
      .link_change_raw_flag(linkRaw), .link_change_masked_flag(linkMsk), .aliveMap(alive), .linkMap(link),
      .mgmt_clock_pin(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe));
   pmp_phy_model phy (.mdc(mdc), .mdioLine(mdioIn), .linkClk(linkClk), .phyOe(phyOe), .phyOut(phyOut));
   ////////////////////////////////////////////////////////////
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Bounded waits: slots idle, or a poll round
   task automatic wait_idle();
      #1;
      for (int i = 0; i < 3000 && busy !== 2'h0; i++) @(posedge ref_clk);
      #1;
   endtask
   task automatic wait_round();
      int n0;
      phy.seenMask = '0;
      for (int i = 0; i < 40000 && phy.seenMask !== 32'hFFFFFFFF; i++) @(posedge ref_clk);
      n0 = phy.frames;
      for (int i = 0; i < 3000 && phy.frames == n0; i++) @(posedge ref_clk);
      #1;
   endtask
   task automatic t_idle();
      repeat (300) @(posedge ref_clk);
      chk("frames", 0, phy.frames);
      $display("test idle done");
   endtask
   task automatic t_poll();
      @(posedge ref_clk);
      enable <= 1'b1;
      for (int i = 0; i < 3000 && phy.frames == 0; i++) @(posedge ref_clk);
      chk("preambleOn", 1, phy.lastPre >= 32);
      preambleOff <= 1'b1;
      wait_round();
      chk("polled", 32'hFFFFFFFF, phy.seenMask);
      chk("preambleOff", 1, phy.lastPre < 32);
      chk("alive", 32'h24, alive);
      chk("link", 32'h20, link);
      chk("linkRawOff", 0, linkRaw);
      $display("test poll done");
   endtask
   task automatic t_link();
      @(posedge ref_clk);
      linkIrqEn <= 1'b1;
      phy.present[2] = 1'b0;
      phy.linkUp[5] = 1'b0;
      wait_round();
      chk("aliveGone", 32'h20, alive);
      chk("linkDown", 0, link);
      chk("linkRaw", 1, linkRaw);
      chk("linkMasked", 1, linkMsk);
      @(posedge ref_clk);
      linkClr <= 1'b1;
      @(posedge ref_clk);
      linkClr <= 1'b0;
      #1;
      chk("linkCleared", 0, linkRaw);
      $display("test link done");
   endtask
   task automatic t_read();
      phy.present[2] = 1'b1;
      @(posedge ref_clk);
      maskSet <= 2'h1;
      phyAddr[0] <= 5'h02;
      regAddr[0] <= 5'h03;
      @(posedge ref_clk);
      maskSet <= 2'h0;
      launch <= 2'h1;
      @(posedge ref_clk);
      launch <= 2'h0;
      #1;
      chk("busy0", 1, busy[0]);
      wait_idle();
      chk("readData", {3'h5, 5'h02, 5'h03, 3'h2}, rdData[0]);
      chk("ack0", 1, ack[0]);
      chk("irq", 1, irq);
      chk("aliveBack", 32'h24, alive);
      @(posedge ref_clk);
      doneClr <= 2'h1;
      @(posedge ref_clk);
      doneClr <= 2'h0;
      #1;
      chk("rawCleared", 0, rawF);
      $display("test read done");
   endtask
   task automatic t_pair();
      chk("slotsFree", 0, busy);
      phy.logPhy.delete();
      @(posedge ref_clk);
      maskClr <= 2'h1;
      wrDir <= 2'h1;
      {phyAddr[0], regAddr[0], wrData[0]} <= {5'h05, 5'h04, 16'hBEEF};
      {phyAddr[1], regAddr[1]} <= {5'h07, 5'h06};
      @(posedge ref_clk);
      maskClr <= 2'h0;
      launch <= 2'h3;
      @(posedge ref_clk);
      launch <= 2'h0;
      wait_idle();
      chk("order", {5'h07, 5'h05}, {phy.logPhy[0], phy.logPhy[1]});
      chk("wrData", 16'hBEEF, phy.wrData);
      chk("raw", 3, rawF);
      chk("masked", 0, mskF);
      chk("ack1", 0, ack[1]);
      $display("test pair done");
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      {sys_rst, enable, preambleOff, linkIrqEn, linkClr} = 5'h10;
      {launch, wrDir, doneClr, maskSet, maskClr} = '0;
      {phyAddr, regAddr, wrData} = '0;
      divide = 16'h0009;
      monAddr = 5'h05;
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_idle();
      t_poll();
      t_link();
      t_read();
      t_pair();
      conclude();
   end
   // Cut a hang short
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 90000) begin
         fails++;
         conclude();
      end
   end
endmodule
